/* verilog/tpio_top.v */
// Purpose: Pin I/O control of general register A, timer channels 4 and 5
// Assumes: Counter values and channel 3 event arrive synchronous to CLK
// Notes:   Registers over APB, zero wait states; unmapped access errors
`timescale 1ns/100ps
`default_nettype none
`include "tpio_defines.vh"

// Overview of operation
// - Output compare, low bits 01: drive pin low at each compare match.
// - Output compare, low bits 10: drive pin high at each compare match.
// - Output compare, low bits 11: invert pin level at each compare match.
// - Input capture, low bits 00: load counter into register on rising pin edge.
// - Input capture, low bits 01: load counter on falling pin edge.
// - Input capture, bit 1 set: capture on both edges, bit 0 ignored.
// - Channel 4, top two bits set: capture source is channel 3 register A event.
// - Channel 4 cascaded: capture counter on channel 3 compare match or capture.
module tpio_top #(
    parameter CW = 16
) (
    // Clock and reset
    input  wire          CLK,
    input  wire          RESET_N,
    // APB slave
    input  wire          PSEL,
    input  wire          PENABLE,
    input  wire          PWRITE,
    input  wire [7:0]    PADDR,
    input  wire [31:0]   PWDATA,
    output wire          PREADY,
    output wire          PSLVERR,
    output reg  [31:0]   PRDATA,
    // Timer counters and channel 3 event
    input  wire [CW-1:0] CNT4,
    input  wire [CW-1:0] CNT5,
    input  wire          CH3_GRA_EVENT,
    // Channel 4 pin A
    input  wire          CH4_PIN_A_IN,
    output wire          CH4_PIN_A_OUT,
    output wire          CH4_PIN_A_OE,
    // Channel 5 pin A
    input  wire          CH5_PIN_A_IN,
    output wire          CH5_PIN_A_OUT,
    output wire          CH5_PIN_A_OE,
    // Event pulses, one cycle, registered
    output reg           CH4_MATCH,
    output reg           CH4_CAPTURE,
    output reg           CH5_MATCH,
    output reg           CH5_CAPTURE
);

    // Storage
    reg [7:0]    ch4_pin_io_control_r;
    reg [7:0]    ch5_pin_io_control_r;
    reg [CW-1:0] ch4_general_reg_a_r;
    reg [CW-1:0] ch5_general_reg_a_r;
    reg          pin4_r;
    reg          pin5_r;
    reg          in4_prev_r;
    reg          in5_prev_r;
    reg          eq4_prev_r;
    reg          eq5_prev_r;

    // Bus decode
    wire         acc     = PSEL & PENABLE;
    wire         wr      = acc & PWRITE;
    wire         hit_c4  = (PADDR == `TPIO_OFF_CH4_CTL);
    wire         hit_c5  = (PADDR == `TPIO_OFF_CH5_CTL);
    wire         hit_g4  = (PADDR == `TPIO_OFF_CH4_GRA);
    wire         hit_g5  = (PADDR == `TPIO_OFF_CH5_GRA);
    wire         hit_st  = (PADDR == `TPIO_OFF_STATUS);
    wire         mapped  = hit_c4 | hit_c5 | hit_g4 | hit_g5 | hit_st;
    // Status is read only, so a write to it is refused too
    wire         bad     = ~mapped | (PWRITE & hit_st);

    assign PREADY  = 1'b1;
    assign PSLVERR = acc & bad;

    // Output compare mode when the top field bit is clear
    function is_compare;
        input [7:0] ctl;
        begin
            is_compare = ~ctl[`TPIO_BIT_FUNC];
        end
    endfunction

    // Pin level after a compare match
    function next_level;
        input [7:0] ctl;
        input       lvl;
        begin
            case (ctl[`TPIO_BIT_ACT_HI:`TPIO_BIT_ACT_LO])
                `TPIO_ACT_LOW:    next_level = 1'b0;
                `TPIO_ACT_HIGH:   next_level = 1'b1;
                `TPIO_ACT_TOGGLE: next_level = ~lvl;
                default:          next_level = lvl;
            endcase
        end
    endfunction

    // Pin-edge capture decision
    function edge_hit;
        input [7:0] ctl;
        input       rise;
        input       fall;
        begin
            if (ctl[`TPIO_BIT_ACT_HI]) begin
                edge_hit = rise | fall;
            end else if (ctl[`TPIO_BIT_ACT_LO]) begin
                edge_hit = fall;
            end else begin
                edge_hit = rise;
            end
        end
    endfunction

    // Edges of the pin inputs and first cycle of a counter match
    wire rise4 = CH4_PIN_A_IN & ~in4_prev_r;
    wire fall4 = ~CH4_PIN_A_IN & in4_prev_r;
    wire rise5 = CH5_PIN_A_IN & ~in5_prev_r;
    wire fall5 = ~CH5_PIN_A_IN & in5_prev_r;
    wire eq4   = (CNT4 == ch4_general_reg_a_r);
    wire eq5   = (CNT5 == ch5_general_reg_a_r);
    // One match per arrival, so a stalled counter does not toggle repeatedly
    wire match4 = is_compare(ch4_pin_io_control_r) & eq4 & ~eq4_prev_r;
    wire match5 = is_compare(ch5_pin_io_control_r) & eq5 & ~eq5_prev_r;

    // Channel 4 capture: cascaded source replaces the pin
    wire casc4 = ch4_pin_io_control_r[`TPIO_BIT_FUNC]
               & ch4_pin_io_control_r[`TPIO_BIT_LVL_SRC];
    wire cap4  = ~is_compare(ch4_pin_io_control_r)
               & (casc4 ? CH3_GRA_EVENT
                        : edge_hit(ch4_pin_io_control_r, rise4, fall4));
    // Channel 5 never looks at bit 2 in capture mode
    wire cap5  = ~is_compare(ch5_pin_io_control_r)
               & edge_hit(ch5_pin_io_control_r, rise5, fall5);

    // Output enable: compare mode with a non-zero action
    assign CH4_PIN_A_OE  = is_compare(ch4_pin_io_control_r)
        & (ch4_pin_io_control_r[`TPIO_BIT_ACT_HI:`TPIO_BIT_ACT_LO] != `TPIO_ACT_OFF);
    assign CH5_PIN_A_OE  = is_compare(ch5_pin_io_control_r)
        & (ch5_pin_io_control_r[`TPIO_BIT_ACT_HI:`TPIO_BIT_ACT_LO] != `TPIO_ACT_OFF);
    assign CH4_PIN_A_OUT = pin4_r;
    assign CH5_PIN_A_OUT = pin5_r;

    // Control registers and pin levels
    always @(posedge CLK) begin
        if (!RESET_N) begin
            ch4_pin_io_control_r <= `TPIO_CTL_RST;
            ch5_pin_io_control_r <= `TPIO_CTL_RST;
            pin4_r               <= 1'b0;
            pin5_r               <= 1'b0;
        end else begin
            // A control write loads the initial level from bit 2
            if (wr & hit_c4) begin
                ch4_pin_io_control_r <= PWDATA[7:0];
                pin4_r               <= PWDATA[`TPIO_BIT_LVL_SRC];
            end else if (match4) begin
                pin4_r <= next_level(ch4_pin_io_control_r, pin4_r);
            end
            if (wr & hit_c5) begin
                ch5_pin_io_control_r <= PWDATA[7:0];
                pin5_r               <= PWDATA[`TPIO_BIT_LVL_SRC];
            end else if (match5) begin
                pin5_r <= next_level(ch5_pin_io_control_r, pin5_r);
            end
        end
    end

    // General registers A; a capture wins over a software write
    always @(posedge CLK) begin
        if (!RESET_N) begin
            ch4_general_reg_a_r <= `TPIO_GRA_RST;
            ch5_general_reg_a_r <= `TPIO_GRA_RST;
        end else begin
            if (cap4) begin
                ch4_general_reg_a_r <= CNT4;
            end else if (wr & hit_g4) begin
                ch4_general_reg_a_r <= PWDATA[CW-1:0];
            end
            if (cap5) begin
                ch5_general_reg_a_r <= CNT5;
            end else if (wr & hit_g5) begin
                ch5_general_reg_a_r <= PWDATA[CW-1:0];
            end
        end
    end

    // Edge and match history, event pulses
    always @(posedge CLK) begin
        if (!RESET_N) begin
            in4_prev_r  <= 1'b0;
            in5_prev_r  <= 1'b0;
            eq4_prev_r  <= 1'b0;
            eq5_prev_r  <= 1'b0;
            CH4_MATCH   <= 1'b0;
            CH5_MATCH   <= 1'b0;
            CH4_CAPTURE <= 1'b0;
            CH5_CAPTURE <= 1'b0;
        end else begin
            in4_prev_r  <= CH4_PIN_A_IN;
            in5_prev_r  <= CH5_PIN_A_IN;
            eq4_prev_r  <= eq4;
            eq5_prev_r  <= eq5;
            CH4_MATCH   <= match4;
            CH5_MATCH   <= match5;
            CH4_CAPTURE <= cap4;
            CH5_CAPTURE <= cap5;
        end
    end

    // Read data, registered for the access phase edge
    always @(posedge CLK) begin
        if (!RESET_N) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL & ~PENABLE & ~PWRITE) begin
            PRDATA <= 32'h00000000;
            if (hit_c4) begin
                PRDATA[7:0] <= ch4_pin_io_control_r;
            end else if (hit_c5) begin
                PRDATA[7:0] <= ch5_pin_io_control_r;
            end else if (hit_g4) begin
                PRDATA[CW-1:0] <= ch4_general_reg_a_r;
            end else if (hit_g5) begin
                PRDATA[CW-1:0] <= ch5_general_reg_a_r;
            end else if (hit_st) begin
                PRDATA[`TPIO_ST_PIN4] <= pin4_r;
                PRDATA[`TPIO_ST_PIN5] <= pin5_r;
                PRDATA[`TPIO_ST_OE4]  <= CH4_PIN_A_OE;
                PRDATA[`TPIO_ST_OE5]  <= CH5_PIN_A_OE;
            end
        end
    end

endmodule
`default_nettype wire

/* inc/tpio_defines.vh */
// Purpose: Constants for the channel 4/5 pin I/O control block
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes:   Field bits live in the low nibble of each control register
`ifndef TPIO_DEFINES_VH
`define TPIO_DEFINES_VH

// Register byte offsets
`define TPIO_OFF_CH4_CTL   8'h00
`define TPIO_OFF_CH5_CTL   8'h04
`define TPIO_OFF_CH4_GRA   8'h08
`define TPIO_OFF_CH5_GRA   8'h0c
`define TPIO_OFF_STATUS    8'h10

// Field positions inside a control register
`define TPIO_BIT_FUNC      3
`define TPIO_BIT_LVL_SRC   2
`define TPIO_BIT_ACT_HI    1
`define TPIO_BIT_ACT_LO    0

// Action codes on the low two bits
`define TPIO_ACT_OFF       2'h0
`define TPIO_ACT_LOW       2'h1
`define TPIO_ACT_HIGH      2'h2
`define TPIO_ACT_TOGGLE    2'h3

// Reset values
`define TPIO_CTL_RST       8'h00
`define TPIO_GRA_RST       16'hffff

// Status register bit positions
`define TPIO_ST_PIN4       0
`define TPIO_ST_PIN5       1
`define TPIO_ST_OE4        2
`define TPIO_ST_OE5        3

`endif

/* bench/tpio_pin_model.sv */
// Purpose: Far side of the channel 4/5 timer pins
// Assumes: Far side drives its level whenever the block does not
// Notes:   Feeds the resolved level back to the pin input
`timescale 1ns/100ps
`default_nettype none
module tpio_pin_model (
    // Block side and far side
    input wire logic out,
    input wire logic oe,
    input wire logic ext,
    output logic     pin
);
    // Own drive wins while enabled, so compare output also shows at the input
    assign pin = oe ? out : ext;
endmodule
`default_nettype wire

/* bench/tpio_checker.sv */
// Purpose: Port assertions for the pin I/O control block
// Assumes: Control fields shadowed from APB writes
// Notes:   Bound to the top module below
`timescale 1ns/100ps
`default_nettype none
module tpio_checker (
    // Clock, reset, APB
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    // Pins and events
    input wire logic        CH3_GRA_EVENT,
    input wire logic        CH4_PIN_A_IN,
    input wire logic        CH4_PIN_A_OUT,
    input wire logic        CH4_PIN_A_OE,
    input wire logic        CH5_PIN_A_IN,
    input wire logic        CH4_MATCH,
    input wire logic        CH4_CAPTURE,
    input wire logic        CH5_CAPTURE
);
    logic       wr, w4_r, m4;
    logic [3:0] c4_r, c5_r;
    assign wr = PSEL && PENABLE && PWRITE;
    assign m4 = CH4_MATCH && !w4_r && !c4_r[3];
    // Shadow fields; delayed write flag masks a write that beats a match
    always_ff @(posedge CLK) begin
        w4_r <= RESET_N && wr && PADDR == 8'h00;
        if (!RESET_N) c4_r <= 4'h0;
        else if (wr && PADDR == 8'h00) c4_r <= PWDATA[3:0];
        if (!RESET_N) c5_r <= 4'h0;
        else if (wr && PADDR == 8'h04) c5_r <= PWDATA[3:0];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_oe_mode: assert property (
        CH4_PIN_A_OE == (!c4_r[3] && c4_r[1:0] != 2'h0)) else $error("ch4 oe");
    a_init_level: assert property (
        wr && PADDR == 8'h00 && !PWDATA[3] |=> CH4_PIN_A_OUT == $past(PWDATA[2]))
        else $error("ch4 init level");
    a_match_low: assert property (
        m4 && c4_r[1:0] == 2'h1 |-> !CH4_PIN_A_OUT) else $error("ch4 low");
    a_match_high: assert property (
        m4 && c4_r[1:0] == 2'h2 |-> CH4_PIN_A_OUT) else $error("ch4 high");
    a_match_toggle: assert property (
        m4 && c4_r[1:0] == 2'h3 |-> CH4_PIN_A_OUT != $past(CH4_PIN_A_OUT))
        else $error("ch4 toggle");
    a_cap_rise: assert property (
        c5_r[3] && c5_r[1:0] == 2'h0 && $rose(CH5_PIN_A_IN) |=> CH5_CAPTURE)
        else $error("ch5 rise");
    a_cap_fall: assert property (
        c5_r[3] && c5_r[1:0] == 2'h1 && $fell(CH5_PIN_A_IN) |=> CH5_CAPTURE)
        else $error("ch5 fall");
    a_cap_both: assert property (
        c4_r[3:1] == 3'h5 && $changed(CH4_PIN_A_IN) |=> CH4_CAPTURE) else $error("ch4 both");
    a_cascade_cap: assert property (
        c4_r[3:2] == 2'h3 && CH3_GRA_EVENT |=> CH4_CAPTURE) else $error("ch4 cascade");
    a_ch5_pin_only: assert property (
        CH5_CAPTURE |-> $past(CH5_PIN_A_IN) != $past(CH5_PIN_A_IN, 2)) else $error("ch5 source");
endmodule
bind tpio_top tpio_checker u_chk (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .CH3_GRA_EVENT(CH3_GRA_EVENT), .CH4_PIN_A_IN(CH4_PIN_A_IN), .CH4_PIN_A_OUT(CH4_PIN_A_OUT),
    .CH4_PIN_A_OE(CH4_PIN_A_OE), .CH5_PIN_A_IN(CH5_PIN_A_IN), .CH4_MATCH(CH4_MATCH),
    .CH4_CAPTURE(CH4_CAPTURE), .CH5_CAPTURE(CH5_CAPTURE));
`default_nettype wire

/* bench/tb_tpio_top.sv */
// Purpose: Self-checking bench for the pin I/O control block
// Assumes: APB master waits for PREADY; far side drives idle pins
// Notes:   Random values from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module tb_tpio_top;
    logic        CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, ev = 0, slv, a;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, rd, d;
    logic [15:0] cnt [2] = '{16'h0, 16'h0};
    logic [15:0] v, w;
    logic [1:0]  ext = 2'h0;
    wire  [1:0]  out, oe, pin, mt;
    wire  [31:0] PRDATA;
    wire         PREADY, PSLVERR;
    int          error_cnt = 0, n_tests = 0;
    // 125 MHz clock
    always #4 CLK = ~CLK;
    tpio_top #(.CW(16)) uut (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PRDATA(PRDATA), .CNT4(cnt[0]), .CNT5(cnt[1]), .CH3_GRA_EVENT(ev),
        .CH4_PIN_A_IN(pin[0]), .CH4_PIN_A_OUT(out[0]), .CH4_PIN_A_OE(oe[0]),
        .CH5_PIN_A_IN(pin[1]), .CH5_PIN_A_OUT(out[1]), .CH5_PIN_A_OE(oe[1]),
        .CH4_MATCH(mt[0]), .CH4_CAPTURE(), .CH5_MATCH(mt[1]), .CH5_CAPTURE());
    tpio_pin_model p4 (.out(out[0]), .oe(oe[0]), .ext(ext[0]), .pin(pin[0]));
    tpio_pin_model p5 (.out(out[1]), .oe(oe[1]), .ext(ext[1]), .pin(pin[1]));
    // Verdict and end of run
    task stop_test();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(string s, logic [31:0] g, logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    // One APB transfer; request held until PREADY is sampled high
    task apb(logic wr, logic [7:0] ad, logic [31:0] wd);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= ad;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        rd = PRDATA;
        slv = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1) begin
            error_cnt++;
            stop_test();
        end
    endtask
    // Pin level after one compare match
    function logic exp_oc(logic [3:0] c);
        return c[1:0] == 2'h0 ? c[2] : c[1:0] == 2'h3 ? ~c[2] : c[1];
    endfunction
    // Register value after a pin edge (counter v) then a channel 3 event (counter w)
    function logic [31:0] exp_gra(int ch, logic [3:0] c, logic rise, logic [15:0] v, w);
        if (ch == 0 && c[2]) return {16'h0, w};
        return (c[1] || c[0] != rise) ? {16'h0, v} : 32'h0;
    endfunction
    // Main sequence: reset, unmapped read, every compare code, every capture code
    initial begin
        void'($urandom(64366));
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        apb(0, 8'h14, 0);
        chk("unmapped", {rd[30:0], slv}, 32'h1);
        // Register A of channel 5 comes out of reset all ones
        apb(0, 8'h0c, 0);
        chk("gra reset", rd, 32'h0000ffff);
        for (int ch = 0; ch < 2; ch++)
            for (int k = 0; k < 8; k++) begin
                d = ($urandom() & 32'hfffffff0) | 32'(k);
                v = 16'($urandom());
                apb(1, 8'(ch * 4), d);
                @(negedge CLK);
                chk("oe", oe[ch], k[1:0] != 2'h0);
                chk("init", out[ch], k[2]);
                apb(0, 8'(ch * 4), 0);
                chk("ctl", rd, d & 32'hff);
                apb(1, 8'(8 + ch * 4), {16'h0, v});
                @(posedge CLK);
                cnt[ch] <= v;
                @(posedge CLK);
                cnt[ch] <= ~v;
                @(negedge CLK);
                chk("match", out[ch], exp_oc(4'(k)));
                chk("match pulse", mt[ch], 1'b1);
            end
        // Status is read only; both channels left in toggle mode
        apb(1, 8'h10, 32'hf);
        chk("status wr err", 32'(slv), 32'h1);
        apb(0, 8'h10, 0);
        chk("status", rd, {28'h0, 2'b11, exp_oc(4'h7), exp_oc(4'h7)});
        for (int ch = 0; ch < 2; ch++)
            for (int k = 8; k < 16; k++) begin
                a = k[0] ^ k[2];
                v = 16'($urandom()) | 16'h1;
                w = 16'($urandom()) | 16'h1;
                apb(1, 8'(ch * 4), 32'(k));
                ext[ch] <= a;
                apb(1, 8'(8 + ch * 4), 0);
                ext[ch] <= ~a;
                cnt[ch] <= v;
                @(posedge CLK);
                cnt[ch] <= w;
                ev <= 1'b1;
                @(posedge CLK);
                ev <= 1'b0;
                apb(0, 8'(8 + ch * 4), 0);
                chk("capture", rd, exp_gra(ch, 4'(k), ~a, v, w));
            end
        // Reset in mid-run must restore pins, enables and register A
        @(posedge CLK);
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        @(negedge CLK);
        chk("reset pins", {oe, out}, 32'h0);
        apb(0, 8'h08, 0);
        chk("gra reset", rd, 32'h0000ffff);
        stop_test();
    end
endmodule
`default_nettype wire
